// ==== src/tap_event_pkg.sv ====
// Register map, field layout and bus constants for the tap interrupt block
package tap_event_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] CFG_INDEX = 8'h38;
	localparam logic [7:0] SRC_INDEX = 8'h39;
	localparam logic [7:0] STATUS_INDEX = 8'h40;
	localparam logic [7:0] MASK_INDEX = 8'h41;
	localparam int INDEX_LSB = 2;
	localparam int INDEX_W = 8;
	// Tap configuration and source fields
	localparam int AXIS_COUNT = 3;
	localparam int FLAG_W = 6;
	localparam int LATCH_BIT = 6;
	localparam int ACTIVE_BIT = 6;
	localparam logic [6:0] CFG_RESET = 7'h00;
	localparam logic [5:0] FLAGS_RESET = 6'h00;
	// Interrupt status and mask layout
	localparam int EVT_W = 2;
	localparam int EVT_SINGLE = 0;
	localparam int EVT_DOUBLE = 1;
	localparam logic [1:0] EVT_RESET = 2'h0;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage : tap_event_pkg

// ==== src/reg_bus_if.sv ====
// Internal register access carrier between the bus port and the register file
`timescale 1ns/100ps
`default_nettype none
interface reg_bus_if #(parameter int ADDR_W = 12);
	logic wrEn;
	logic [ADDR_W-1:0] wrAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic wrOk;
	logic rdEn;
	logic [ADDR_W-1:0] rdAddr;
	logic [31:0] rdData;
	logic rdOk;
	modport port (output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
		input wrOk, rdData, rdOk);
	modport regs (input wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
		output wrOk, rdData, rdOk);
endinterface : reg_bus_if
`default_nettype wire

// ==== src/tap_axil_port.sv ====
// AXI4-Lite slave front end turning bus traffic into register strobes
`timescale 1ns/100ps
`default_nettype none
module tap_axil_port
	import tap_event_pkg::*;
#(
	parameter int ADDR_W = 12
)(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cke,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	reg_bus_if.port bus
);
	logic awHeld;
	logic wHeld;
	logic [ADDR_W-1:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	wire awTake = awvalid && awready;
	wire wTake = wvalid && wready;
	wire doWrite = awHeld && wHeld && !bvalid;
	wire next_awHeld = awHeld ? !doWrite : awTake;
	wire next_wHeld = wHeld ? !doWrite : wTake;

	// Strobes only fire while enabled, so the register file never sees frozen cycles
	assign bus.wrEn = cke && doWrite;
	assign bus.wrAddr = awAddr;
	assign bus.wrData = wData;
	assign bus.wrStrb = wStrb;
	assign bus.rdEn = cke && arvalid && arready;
	assign bus.rdAddr = araddr;

	// Address and data are held apart, so either may come first
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			awAddr <= '0;
			wData <= DATA_ZERO;
			wStrb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end
		else if (cke)
		begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awready <= !next_awHeld;
			wready <= !next_wHeld;
			if (awTake)
				awAddr <= awaddr;
			if (wTake)
			begin
				wData <= wdata;
				wStrb <= wstrb;
			end
			if (doWrite)
			begin
				bvalid <= 1'b1;
				bresp <= bus.wrOk ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	// One read in flight; data captured at acceptance
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= DATA_ZERO;
			rresp <= RESP_OKAY;
		end
		else if (cke)
		begin
			if (arvalid && arready)
			begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= bus.rdData;
				rresp <= bus.rdOk ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rvalid && rready)
			begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
			else if (!rvalid)
				arready <= 1'b1;
		end
	end
endmodule : tap_axil_port
`default_nettype wire

// ==== src/tap_source_flags.sv ====
// Per-axis single and double tap flags with latched or following behaviour
`timescale 1ns/100ps
`default_nettype none
module tap_source_flags
	import tap_event_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cke,
	input wire logic [AXIS_COUNT-1:0] singleTap,
	input wire logic [AXIS_COUNT-1:0] doubleTap,
	input wire logic [6:0] tapConfig,
	input wire logic readClear,
	output logic [FLAG_W-1:0] flags
);
	wire latched = tapConfig[LATCH_BIT];
	logic [FLAG_W-1:0] tapHit;
	logic [FLAG_W-1:0] next_flags;

	// Enable gating per axis; set beats the read clear
	for (genvar a = 0; a < AXIS_COUNT; a++)
	begin : g_axis
		assign tapHit[2*a] = singleTap[a] && tapConfig[2*a];
		assign tapHit[2*a+1] = doubleTap[a] && tapConfig[2*a+1];
		// Held in latched mode, following otherwise
		assign next_flags[2*a] = latched ? ((flags[2*a] && !readClear) || tapHit[2*a])
			: tapHit[2*a];
		assign next_flags[2*a+1] = latched ? ((flags[2*a+1] && !readClear) || tapHit[2*a+1])
			: tapHit[2*a+1];
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			flags <= FLAGS_RESET;
		else if (cke)
			flags <= next_flags;
	end
endmodule : tap_source_flags
`default_nettype wire

// ==== src/tap_event_interrupt_logic.sv ====
// Tap interrupt configuration, source flags and AXI4-Lite register file
`timescale 1ns/100ps
`default_nettype none
module tap_event_interrupt_logic
	import tap_event_pkg::*;
#(
	parameter int ADDR_W = 12
)(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cke,
	input wire logic [AXIS_COUNT-1:0] singleTap,
	input wire logic [AXIS_COUNT-1:0] doubleTap,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);
	reg_bus_if #(.ADDR_W(ADDR_W)) bus ();

	logic [6:0] tapConfig;
	logic [FLAG_W-1:0] flags;
	logic [EVT_W-1:0] intStatus;
	logic [EVT_W-1:0] intMask;

	// Bus front end; every bus output is a flop inside it
	tap_axil_port #(.ADDR_W(ADDR_W)) u_port (
		.core_clk(core_clk),
		.reset(reset),
		.cke(cke),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.bus(bus)
	);

	// Word decode: low two address bits ignored, index above them
	wire [INDEX_W-1:0] wrIndex = bus.wrAddr[INDEX_LSB +: INDEX_W];
	wire [INDEX_W-1:0] rdIndex = bus.rdAddr[INDEX_LSB +: INDEX_W];
	wire wrUpper = (bus.wrAddr >> (INDEX_LSB + INDEX_W)) == '0;
	wire rdUpper = (bus.rdAddr >> (INDEX_LSB + INDEX_W)) == '0;
	wire wrCfg = wrUpper && wrIndex == CFG_INDEX;
	wire wrSrc = wrUpper && wrIndex == SRC_INDEX;
	wire wrStatus = wrUpper && wrIndex == STATUS_INDEX;
	wire wrMask = wrUpper && wrIndex == MASK_INDEX;
	wire rdCfg = rdUpper && rdIndex == CFG_INDEX;
	wire rdSrc = rdUpper && rdIndex == SRC_INDEX;
	wire rdStatus = rdUpper && rdIndex == STATUS_INDEX;
	wire rdMask = rdUpper && rdIndex == MASK_INDEX;
	wire lane0 = bus.wrStrb[0];

	// Source is read only; a write there is answered with an error
	assign bus.wrOk = wrCfg || wrStatus || wrMask;
	assign bus.rdOk = rdCfg || rdSrc || rdStatus || rdMask;

	// Active flag is derived, so it can never disagree with the flags
	wire anyActive = |flags;
	wire [7:0] sourceValue = {1'b0, anyActive, flags};
	wire [7:0] configValue = {1'b0, tapConfig};

	// Read mux; narrow registers sit in the low bits
	assign bus.rdData = rdCfg ? {24'h00_0000, configValue} :
		rdSrc ? {24'h00_0000, sourceValue} :
		rdStatus ? {30'h0000_0000, intStatus} :
		rdMask ? {30'h0000_0000, intMask} : DATA_ZERO;

	// Read side effect: a source read frees the held flags in latched mode
	wire latched = tapConfig[LATCH_BIT];
	wire readClear = bus.rdEn && rdSrc && latched;

	// Bit 7 of the config write is dropped; it has no storage
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			tapConfig <= CFG_RESET;
		else if (cke && bus.wrEn && wrCfg && lane0)
			tapConfig <= bus.wrData[6:0];
	end

	// Flag storage and per-axis enable gating
	tap_source_flags u_flags (
		.core_clk(core_clk),
		.reset(reset),
		.cke(cke),
		.singleTap(singleTap),
		.doubleTap(doubleTap),
		.tapConfig(tapConfig),
		.readClear(readClear),
		.flags(flags)
	);

	// Interrupt events: any enabled single or double tap this cycle
	logic [EVT_W-1:0] tapEvent;
	assign tapEvent[EVT_SINGLE] = |(singleTap & {tapConfig[4], tapConfig[2], tapConfig[0]});
	assign tapEvent[EVT_DOUBLE] = |(doubleTap & {tapConfig[5], tapConfig[3], tapConfig[1]});
	wire [EVT_W-1:0] statusClear = (bus.wrEn && wrStatus && lane0)
		? bus.wrData[EVT_W-1:0] : EVT_RESET;
	// New event wins over a write-one clear in the same cycle
	wire [EVT_W-1:0] next_intStatus = (intStatus & ~statusClear) | tapEvent;

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			intStatus <= EVT_RESET;
			intMask <= EVT_RESET;
		end
		else if (cke)
		begin
			intStatus <= next_intStatus;
			if (bus.wrEn && wrMask && lane0)
				intMask <= bus.wrData[EVT_W-1:0];
		end
	end

	// Registered so the pin is glitch free; updates on the same edge as the status
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			irq <= 1'b0;
		else if (cke)
			irq <= |(next_intStatus & intMask);
	end

	// Configuration write lands in the register
	cfg_write_a: assert property (@(posedge core_clk) disable iff (reset)
		bus.wrEn && wrCfg && lane0 && cke
		|=> tapConfig == $past(bus.wrData[6:0]))
		else $error("config write not stored");

	// Latched flags stay until a source read
	latch_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		latched && flags[0] && !readClear
		|=> flags[0])
		else $error("latched flag lost without a read");

	// Disabled double tap never raises its flag
	double_gate_a: assert property (@(posedge core_clk) disable iff (reset)
		!tapConfig[1] && !flags[1] && !$past(tapConfig[1])
		|=> !flags[1])
		else $error("double tap flag set while disabled");

	// Disabled single tap never raises its flag
	single_gate_a: assert property (@(posedge core_clk) disable iff (reset)
		!tapConfig[4] && !flags[4] && !$past(tapConfig[4])
		|=> !flags[4])
		else $error("single tap flag set while disabled");

	// Both enables set: either kind of tap is reported
	pair_either_a: assert property (@(posedge core_clk) disable iff (reset)
		cke && tapConfig[3] && tapConfig[2] && (singleTap[1] || doubleTap[1])
		|=> flags[3] || flags[2])
		else $error("tap not reported with both enables");

	// Source read returns the flags with the active bit
	source_read_a: assert property (@(posedge core_clk) disable iff (reset)
		bus.rdEn && rdSrc
		|=> s_axi_rvalid && s_axi_rdata[7:0] == $past(sourceValue)
			&& s_axi_rdata[ACTIVE_BIT] == $past(|flags))
		else $error("source read data wrong");

	// Active flag is raised one cycle after an enabled tap
	active_flag_a: assert property (@(posedge core_clk) disable iff (reset)
		cke && |tapEvent
		|=> anyActive)
		else $error("active flag missing after tap");

	// Enabled event sets its flag at the next edge
	event_sets_a: assert property (@(posedge core_clk) disable iff (reset)
		cke && tapConfig[0] && singleTap[0]
		|=> flags[0])
		else $error("enabled single tap did not set flag");

	// Latched read with no new events empties the register
	read_clear_a: assert property (@(posedge core_clk) disable iff (reset)
		cke && readClear && !(|singleTap) && !(|doubleTap)
		|=> flags == FLAGS_RESET && !anyActive)
		else $error("source read did not clear latched flags");
endmodule : tap_event_interrupt_logic
`default_nettype wire

// ==== tb/tap_event_interrupt_logic_tb.sv ====
// Self-checking bench for the tap interrupt block over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module tap_event_interrupt_logic_tb
	import tap_event_pkg::*;
;
	localparam logic [11:0] CFG_ADDR = {2'h0, CFG_INDEX, 2'h0};
	localparam logic [11:0] SRC_ADDR = {2'h0, SRC_INDEX, 2'h0};
	localparam logic [11:0] STAT_ADDR = {2'h0, STATUS_INDEX, 2'h0};
	localparam logic [11:0] MASK_ADDR = {2'h0, MASK_INDEX, 2'h0};
	localparam logic [11:0] HOLE_ADDR = 12'h200;
	logic coreClk = 1'b0;
	logic reset = 1'b1;
	logic cke = 1'b1;
	logic [2:0] singleTap = 3'h0;
	logic [2:0] doubleTap = 3'h0;
	logic [11:0] awaddr = 12'h000;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [11:0] araddr = 12'h000;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int errCount = 0;
	int testsRun = 0;
	// Free-running 250 MHz clock
	always #2 coreClk = ~coreClk;
	tap_event_interrupt_logic #(.ADDR_W(12)) uut (.core_clk(coreClk), .reset(reset), .cke(cke),
		.singleTap(singleTap), .doubleTap(doubleTap), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
	task automatic tally_and_finish;
		if (errCount == 0 && testsRun > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			errCount++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Handshakes are sampled mid-cycle so the next rising edge sees the same values
	task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] resp);
		int n;
		logic awHit;
		logic wHit;
		logic bHit;
		n = 0;
		bHit = 1'b0;
		resp = 2'h3;
		@(posedge coreClk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bHit && n < 100)
		begin
			@(negedge coreClk);
			awHit = awvalid && awready;
			wHit = wvalid && wready;
			bHit = bvalid;
			resp = bresp;
			@(posedge coreClk);
			if (awHit)
				awvalid <= 1'b0;
			if (wHit)
				wvalid <= 1'b0;
			n++;
		end
		bready <= 1'b0;
		chk(32'(bHit), 32'h0000_0001);
	endtask : axiWrite
	task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		logic arHit;
		logic rHit;
		n = 0;
		rHit = 1'b0;
		@(posedge coreClk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rHit && n < 100)
		begin
			@(negedge coreClk);
			arHit = arvalid && arready;
			rHit = rvalid;
			d = rdata;
			resp = rresp;
			@(posedge coreClk);
			if (arHit)
				arvalid <= 1'b0;
			n++;
		end
		rready <= 1'b0;
		chk(32'(rHit), 32'h0000_0001);
	endtask : axiRead
	task automatic regWr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		axiWrite(a, d, 4'hF, r);
		chk(32'(r), 32'(er));
	endtask : regWr
	task automatic regCheck(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axiRead(a, d, r);
		chk(d, ed);
		chk(32'(r), 32'(er));
	endtask : regCheck
	// One-cycle detector pulse, then a few idle cycles
	task automatic pulse(input logic [2:0] s, input logic [2:0] d);
		@(posedge coreClk);
		singleTap <= s;
		doubleTap <= d;
		@(posedge coreClk);
		singleTap <= 3'h0;
		doubleTap <= 3'h0;
		repeat (4) @(posedge coreClk);
	endtask : pulse
	task automatic test_reset;
		regCheck(CFG_ADDR, DATA_ZERO, RESP_OKAY);
		regCheck(SRC_ADDR, DATA_ZERO, RESP_OKAY);
		regCheck(STAT_ADDR, DATA_ZERO, RESP_OKAY);
		regCheck(MASK_ADDR, DATA_ZERO, RESP_OKAY);
		chk(32'(irq), 32'h0000_0000);
	endtask : test_reset
	// Every enable pair on every axis, both tap kinds fired, latched
	task automatic test_enable_pairs;
		logic [5:0] f;
		for (int a = 0; a < AXIS_COUNT; a++)
			for (int m = 0; m < 4; m++)
			begin
				f = 6'(m << (2 * a));
				regWr(CFG_ADDR, {25'h000_0000, 1'b1, f}, RESP_OKAY);
				regCheck(CFG_ADDR, {25'h000_0000, 1'b1, f}, RESP_OKAY);
				pulse(3'h7, 3'h7);
				repeat (8) @(posedge coreClk);
				regCheck(SRC_ADDR, {25'h000_0000, |f, f}, RESP_OKAY);
				regCheck(SRC_ADDR, DATA_ZERO, RESP_OKAY);
			end
	endtask : test_enable_pairs
	// Unlatched flags follow the detector and drop with it
	task automatic test_unlatched;
		regWr(CFG_ADDR, 32'h0000_003F, RESP_OKAY);
		@(posedge coreClk);
		singleTap <= 3'h4;
		doubleTap <= 3'h4;
		regCheck(SRC_ADDR, 32'h0000_0070, RESP_OKAY);
		singleTap <= 3'h0;
		doubleTap <= 3'h0;
		repeat (3) @(posedge coreClk);
		regCheck(SRC_ADDR, DATA_ZERO, RESP_OKAY);
	endtask : test_unlatched
	// Unused bit, masked strobe, read-only and unmapped places
	task automatic test_bus_refusals;
		logic [1:0] r;
		regWr(CFG_ADDR, 32'h0000_00FF, RESP_OKAY);
		regCheck(CFG_ADDR, 32'h0000_007F, RESP_OKAY);
		axiWrite(CFG_ADDR, DATA_ZERO, 4'h0, r);
		chk(32'(r), 32'(RESP_OKAY));
		regCheck(CFG_ADDR, 32'h0000_007F, RESP_OKAY);
		regWr(SRC_ADDR, 32'h0000_007F, RESP_SLVERR);
		regCheck(SRC_ADDR, DATA_ZERO, RESP_OKAY);
		regWr(HOLE_ADDR, 32'h0000_00FF, RESP_SLVERR);
		regCheck(HOLE_ADDR, DATA_ZERO, RESP_SLVERR);
	endtask : test_bus_refusals
	// Sticky status, mask gating and write-one-to-clear on the level output
	task automatic test_interrupt;
		regWr(STAT_ADDR, 32'h0000_0003, RESP_OKAY);
		regCheck(STAT_ADDR, DATA_ZERO, RESP_OKAY);
		pulse(3'h2, 3'h0);
		regCheck(STAT_ADDR, 32'h0000_0001, RESP_OKAY);
		chk(32'(irq), 32'h0000_0000);
		regWr(MASK_ADDR, 32'h0000_0001, RESP_OKAY);
		regCheck(MASK_ADDR, 32'h0000_0001, RESP_OKAY);
		repeat (3) @(posedge coreClk);
		chk(32'(irq), 32'h0000_0001);
		pulse(3'h0, 3'h1);
		regWr(STAT_ADDR, 32'h0000_0001, RESP_OKAY);
		regCheck(STAT_ADDR, 32'h0000_0002, RESP_OKAY);
		chk(32'(irq), 32'h0000_0000);
		regWr(MASK_ADDR, 32'h0000_0003, RESP_OKAY);
		repeat (3) @(posedge coreClk);
		chk(32'(irq), 32'h0000_0001);
		regWr(STAT_ADDR, 32'h0000_0002, RESP_OKAY);
		repeat (3) @(posedge coreClk);
		chk(32'(irq), 32'h0000_0000);
	endtask : test_interrupt
	// Main sequence
	initial
	begin
		repeat (8) @(posedge coreClk);
		reset <= 1'b0;
		repeat (2) @(posedge coreClk);
		test_reset();
		test_enable_pairs();
		test_unlatched();
		test_bus_refusals();
		test_interrupt();
		tally_and_finish();
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		repeat (50000) @(posedge coreClk);
		errCount++;
		tally_and_finish();
	end
endmodule : tap_event_interrupt_logic_tb
`default_nettype wire
